// file: core/vprt_dur_cmp.sv
// duration comparator for the pattern time limitation
`timescale 1ns/1ps
module vprt_dur_cmp
  import vprt_pkg::*;
(
  input  wire vprt_tmode_e       mode,
  input  wire logic [DUR_W-1:0]  dur,
  input  wire logic [DUR_W-1:0]  t1,
  input  wire logic [DUR_W-1:0]  tvar,
  input  wire logic [DUR_W-1:0]  t2,
  output logic                   hit
);

  logic [DUR_W-1:0] band_lo;
  logic [DUR_W:0]   band_hi;

  // band t1 +/- variation; clamped so a large variation cannot wrap
  assign band_lo = (tvar > t1) ? '0 : t1 - tvar;
  assign band_hi = {1'b0, t1} + {1'b0, tvar};

  // compare the finished duration against the selected limits
  always_comb begin
    hit = 1'b0;
    unique case (mode)
      TM_TIMEOUT: hit = 1'b0;
      TM_LONGER:  hit = dur > t1;
      TM_SHORTER: hit = dur < t1;
      TM_EQUAL:   hit = dur >= band_lo && {1'b0, dur} <= band_hi;
      TM_UNEQUAL: hit = dur < band_lo || {1'b0, dur} > band_hi;
      TM_INSIDE:  hit = dur > t1 && dur < t2;
      TM_OUTSIDE: hit = dur < t1 || dur > t2;
      default:    hit = 1'b0;
    endcase
  end

endmodule

// file: core/vprt_trigger.sv
// video, pattern and runt trigger qualifier with its register port
//
// How it works
// RQ1: video triggers come only from sync pulse timing, never picture content.
// RQ2: selectable SD/HD standard sets line period and interlaced field handling.
// RQ3: sync polarity is opposite the modulation; triggers sit on sync edges.
// RQ4: frame modes fire on every, odd-only or even-only frame starts.
// RQ5: line-number mode fires at the start of the configured line.
// RQ6: each channel holds high, low or ignored and is compared.
// RQ7: pattern has 2 or 4 analog bits plus 16 logic bits.
// RQ8: matches combine by AND of all defined or OR of any.
// RQ9: without duration, fire when the condition goes true or goes false.
// RQ10: with duration, fire on how long condition held true or false.
// RQ11: timeout fires once the match has lasted the configured time.
// RQ12: longer/shorter fire when the match ends after/before the reference.
// RQ13: equal fires inside reference plus/minus variation; unequal outside it.
// RQ14: inside/outside use lower and upper limits, consistent with the band; the code makes them exclusive where the band is inclusive.
// RQ15: runt is two crossings of one threshold without crossing the other.
// RQ16: negative runt crosses upper twice, never the lower.
// RQ17: positive runt crosses lower twice, never the upper.
// RQ18: runt polarity selects positive, negative or both first slopes.
// RQ19: a failed threshold search leaves both thresholds unchanged.
// RQ20: each trigger is one clock-wide pulse on the trigger output.
// RQ21: comparator levels arrive synchronous, with upper and lower runt levels.
`timescale 1ns/1ps
module vprt_trigger
  import vprt_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              video_level,
  input  wire logic [3:0]        analog_level,
  input  wire logic [15:0]       logic_level,
  input  wire logic              runt_above_upper,
  input  wire logic              runt_above_lower,
  input  wire logic              find_done,
  input  wire logic              find_ok,
  input  wire logic [THR_W-1:0]  find_upper,
  input  wire logic [THR_W-1:0]  find_lower,
  output logic      [THR_W-1:0]  upper_threshold,
  output logic      [THR_W-1:0]  lower_threshold,
  output logic                   trig_out
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  vprt_ctrl_s        ctrl, next_ctrl;
  logic [PAT_W-1:0]  care, next_care;
  logic [PAT_W-1:0]  val, next_val;
  logic [DUR_W-1:0]  t1, next_t1;
  logic [DUR_W-1:0]  tvar, next_tvar;
  logic [DUR_W-1:0]  t2, next_t2;
  logic [LINE_W-1:0] line_num, next_line_num;
  logic [THR_W-1:0]  next_upper, next_lower;
  logic [31:0]       next_rdata;
  logic [15:0]       trig_cnt, next_trig_cnt;
  logic [LINE_W-1:0] line_cnt;
  logic              field_second, frame_odd;

  // register writes; a search result loads thresholds only when it succeeded
  always_comb begin
    next_ctrl     = ctrl;
    next_care     = care;
    next_val      = val;
    next_t1       = t1;
    next_tvar     = tvar;
    next_t2       = t2;
    next_line_num = line_num;
    next_upper    = upper_threshold;
    next_lower    = lower_threshold;
    if (find_done && find_ok) begin // [RQ19]
      next_upper = find_upper;
      next_lower = find_lower;
    end
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: next_ctrl     = vprt_ctrl_s'(reg_wdata[CTRL_W-1:0]);
        OFS_CARE: next_care     = reg_wdata[PAT_W-1:0];
        OFS_VAL:  next_val      = reg_wdata[PAT_W-1:0];
        OFS_T1:   next_t1       = reg_wdata[DUR_W-1:0];
        OFS_VAR:  next_tvar     = reg_wdata[DUR_W-1:0];
        OFS_T2:   next_t2       = reg_wdata[DUR_W-1:0];
        OFS_LINE: next_line_num = reg_wdata[LINE_W-1:0];
        OFS_THR: begin
          next_upper = reg_wdata[31:16];
          next_lower = reg_wdata[15:0];
        end
        default: ;
      endcase
    end
  end

  // read data stands for exactly one cycle; unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: next_rdata = {{(32-CTRL_W){1'b0}}, ctrl};
        OFS_CARE: next_rdata = {12'h000, care};
        OFS_VAL:  next_rdata = {12'h000, val};
        OFS_T1:   next_rdata = {8'h00, t1};
        OFS_VAR:  next_rdata = {8'h00, tvar};
        OFS_T2:   next_rdata = {8'h00, t2};
        OFS_LINE: next_rdata = {21'h000000, line_num};
        OFS_THR:  next_rdata = {upper_threshold, lower_threshold};
        OFS_STAT: next_rdata = {trig_cnt, frame_odd, field_second, 3'h0, line_cnt};
        default:  next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl            <= '0;
      care            <= '0;
      val             <= '0;
      t1              <= RST_T1;
      tvar            <= RST_VAR;
      t2              <= RST_T2;
      line_num        <= RST_LINE;
      upper_threshold <= RST_UPPER;
      lower_threshold <= RST_LOWER;
      reg_rdata       <= 32'h0000_0000;
    end else begin
      ctrl            <= next_ctrl;
      care            <= next_care;
      val             <= next_val;
      t1              <= next_t1;
      tvar            <= next_tvar;
      t2              <= next_t2;
      line_num        <= next_line_num;
      upper_threshold <= next_upper;
      lower_threshold <= next_lower;
      reg_rdata       <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // video sync separator
  // ----------------------------------------------------------------
  logic              sync_now, sync_d, next_sync_d, sync_lead, sync_trail;
  logic [SYNC_W-1:0] sync_w, next_sync_w, gap, next_gap;
  logic [SYNC_W-1:0] std_gap, std_broad;
  logic [LINE_W-1:0] next_line_cnt;
  logic [3:0]        since_v, next_since_v;
  logic              next_field_second, next_frame_odd, interlaced, video_fire;

  // sync is the opposite level of the modulation polarity
  assign sync_now   = ctrl.sync_neg ? ~video_level : video_level; // [RQ3]
  assign sync_lead  = sync_now & ~sync_d;
  assign sync_trail = ~sync_now & sync_d;

  // per standard: 3/4 line rejects half-line pulses, 1/4 line marks broad ones
  always_comb begin
    interlaced = 1'b1;
    std_gap    = SYNC_W'(LINE_CYC_625 * 3 / 4);
    std_broad  = SYNC_W'(LINE_CYC_625 / 4);
    unique case (ctrl.std) // [RQ2]
      STD_PAL, STD_SECAM, STD_576I: ;
      STD_NTSC, STD_PALM: begin
        std_gap   = SYNC_W'(LINE_CYC_525 * 3 / 4);
        std_broad = SYNC_W'(LINE_CYC_525 / 4);
      end
      STD_720P: begin
        interlaced = 1'b0;
        std_gap    = SYNC_W'(LINE_CYC_750 * 3 / 4);
        std_broad  = SYNC_W'(LINE_CYC_750 / 4);
      end
      STD_1080P, STD_1080I: begin
        interlaced = ctrl.std == STD_1080I;
        std_gap    = SYNC_W'(LINE_CYC_1125 * 3 / 4);
        std_broad  = SYNC_W'(LINE_CYC_1125 / 4);
      end
    endcase
  end

  // line edges count lines; a broad pulse ends a field, two fields a frame (one field when progressive)
  always_comb begin
    next_sync_d       = sync_now;
    next_sync_w       = sync_w;
    next_gap          = gap;
    next_line_cnt     = line_cnt;
    next_since_v      = since_v;
    next_field_second = field_second;
    next_frame_odd    = frame_odd;
    video_fire        = 1'b0;
    if (gap != '1)
      next_gap = gap + 12'h001;
    if (sync_lead)
      next_sync_w = 12'h001;
    else if (sync_now && sync_w != '1)
      next_sync_w = sync_w + 12'h001;
    if (sync_lead && gap >= std_gap) begin // [RQ1]
      next_gap      = 12'h000;
      next_line_cnt = line_cnt + 11'h001;
      if (since_v != 4'hF)
        next_since_v = since_v + 4'h1;
      if (ctrl.vsel == VID_ALL_LINES ||
          (ctrl.vsel == VID_LINE_NUM && next_line_cnt == line_num))
        video_fire = 1'b1; // [RQ5]
    end
    if (sync_trail && sync_w >= std_broad && since_v >= VERT_REARM) begin
      next_since_v      = 4'h0;
      next_field_second = interlaced ? ~field_second : 1'b0; // [RQ2]
      if (!interlaced || field_second) begin
        next_frame_odd = ~frame_odd;
        next_line_cnt  = 11'h001;
        if (ctrl.vsel == VID_ALL_FRAMES ||
            (ctrl.vsel == VID_ODD_FRAMES && next_frame_odd) ||
            (ctrl.vsel == VID_EVEN_FRAMES && !next_frame_odd))
          video_fire = 1'b1; // [RQ4]
      end
    end
  end

  // field_second starts high so the first vertical interval opens frame one
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_d       <= 1'b0;
      sync_w       <= 12'h000;
      gap          <= 12'hFFF;
      line_cnt     <= 11'h000;
      since_v      <= 4'hF;
      field_second <= 1'b1;
      frame_odd    <= 1'b0;
    end else begin
      sync_d       <= next_sync_d;
      sync_w       <= next_sync_w;
      gap          <= next_gap;
      line_cnt     <= next_line_cnt;
      since_v      <= next_since_v;
      field_second <= next_field_second;
      frame_odd    <= next_frame_odd;
    end
  end

  // ----------------------------------------------------------------
  // pattern match and duration
  // ----------------------------------------------------------------
  logic [PAT_W-1:0] act_mask, care_eff, pat_in, hits;
  logic             pat_all, pat_any, pat_cond, pat_mon, mon_d, next_mon_d;
  logic [DUR_W-1:0] dur, next_dur;
  logic             dur_hit, pat_fire;

  // absent channels are forced to don't-care
  assign act_mask = {ctrl.mso ? 16'hFFFF : 16'h0000,
                     ctrl.four_ch ? 4'hF : 4'h3}; // [RQ7]
  assign pat_in   = {logic_level, analog_level};
  assign care_eff = care & act_mask;
  assign hits     = ~(pat_in ^ val) & care_eff; // [RQ6]
  assign pat_all  = hits == care_eff;
  assign pat_any  = |hits;
  assign pat_cond = ctrl.pat_or ? pat_any : pat_all; // [RQ8]
  assign pat_mon  = pat_cond ^ ctrl.cond_false;

  vprt_dur_cmp u_cmp (
    .mode (ctrl.tmode),
    .dur  (dur),
    .t1   (t1),
    .tvar (tvar),
    .t2   (t2),
    .hit  (dur_hit)
  );

  // dur is the length of the current run; it saturates rather than wraps
  always_comb begin
    next_mon_d = pat_mon;
    next_dur   = 24'h000000;
    if (pat_mon)
      next_dur = !mon_d ? 24'h000001 : (dur == '1 ? dur : dur + 24'h000001);
    if (!ctrl.duration)
      pat_fire = pat_mon & ~mon_d; // [RQ9]
    else if (ctrl.tmode == TM_TIMEOUT)
      pat_fire = pat_mon && next_dur == t1 && next_dur != dur; // [RQ11]
    else
      pat_fire = ~pat_mon & mon_d & dur_hit; // [RQ10] [RQ12] [RQ13] [RQ14]
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mon_d <= 1'b0;
      dur   <= 24'h000000;
    end else begin
      mon_d <= next_mon_d;
      dur   <= next_dur;
    end
  end

  // ----------------------------------------------------------------
  // runt detector
  // ----------------------------------------------------------------
  vprt_runt_e runt_st, next_runt_st;
  logic       up_d, lo_d, next_up_d, next_lo_d, mid_now;
  logic       pos_hit, neg_hit, runt_fire;

  assign mid_now = runt_above_lower & ~runt_above_upper;

  // a crossing of the far threshold cancels the candidate pulse
  always_comb begin
    next_runt_st = runt_st;
    next_up_d    = runt_above_upper;
    next_lo_d    = runt_above_lower;
    pos_hit      = 1'b0;
    neg_hit      = 1'b0;
    unique case (runt_st)
      RS_IDLE: begin
        if (!lo_d && mid_now)
          next_runt_st = RS_POS;
        else if (up_d && mid_now)
          next_runt_st = RS_NEG;
      end
      RS_POS: begin
        if (runt_above_upper)
          next_runt_st = RS_IDLE; // [RQ15]
        else if (!runt_above_lower) begin
          next_runt_st = RS_IDLE;
          pos_hit      = 1'b1; // [RQ17]
        end
      end
      RS_NEG: begin
        if (!runt_above_lower)
          next_runt_st = RS_IDLE; // [RQ15]
        else if (runt_above_upper) begin
          next_runt_st = RS_IDLE;
          neg_hit      = 1'b1; // [RQ16]
        end
      end
      default: next_runt_st = RS_IDLE;
    endcase
    runt_fire = (pos_hit && ctrl.runt_pol != RP_NEG) ||
                (neg_hit && ctrl.runt_pol != RP_POS); // [RQ18]
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      runt_st <= RS_IDLE;
      up_d    <= 1'b0;
      lo_d    <= 1'b0;
    end else begin
      runt_st <= next_runt_st;
      up_d    <= next_up_d;
      lo_d    <= next_lo_d;
    end
  end

  // ----------------------------------------------------------------
  // trigger output
  // ----------------------------------------------------------------
  logic next_trig;

  // registered so the pulse is clean and exactly one cycle wide
  always_comb begin
    next_trig = 1'b0;
    unique case (ctrl.mode)
      VPRT_MODE_VIDEO:   next_trig = video_fire;
      VPRT_MODE_PATTERN: next_trig = pat_fire;
      VPRT_MODE_RUNT:    next_trig = runt_fire;
      VPRT_MODE_OFF:     next_trig = 1'b0;
    endcase
    next_trig_cnt = next_trig ? trig_cnt + 16'h0001 : trig_cnt;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trig_out <= 1'b0; // [RQ20]
      trig_cnt <= 16'h0000;
    end else begin
      trig_out <= next_trig; // [RQ20]
      trig_cnt <= next_trig_cnt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  trig_pulse_a: assert property (trig_out |=> !trig_out) // [RQ20]
    else $error("trigger pulse longer than one cycle");

  video_edge_a: assert property ( // [RQ3]
    trig_out && $past(ctrl.mode) == VPRT_MODE_VIDEO
    |-> $past(sync_now) != $past(sync_now, 2))
    else $error("video trigger not on a sync edge");

  line_num_a: assert property ( // [RQ5]
    trig_out && $past(ctrl.mode) == VPRT_MODE_VIDEO && $past(ctrl.vsel) == VID_LINE_NUM
    |-> line_cnt == $past(line_num))
    else $error("line trigger on wrong line");

  odd_frame_a: assert property ( // [RQ4]
    trig_out && $past(ctrl.mode) == VPRT_MODE_VIDEO && $past(ctrl.vsel) == VID_ODD_FRAMES
    |-> frame_odd && line_cnt == 11'h001)
    else $error("odd frame trigger on even frame");

  goes_true_a: assert property ( // [RQ9]
    ctrl.mode == VPRT_MODE_PATTERN && !ctrl.duration && pat_mon && !mon_d
    |=> trig_out ##1 !trig_out)
    else $error("pattern edge did not fire once");

  and_combine_a: assert property ( // [RQ8]
    !ctrl.pat_or && care_eff != '0 && ((pat_in ^ val) & care_eff) != '0 |-> !pat_cond)
    else $error("and pattern true with a mismatch");

  timeout_a: assert property ( // [RQ11]
    trig_out && $past(ctrl.mode) == VPRT_MODE_PATTERN && $past(ctrl.duration)
    && $past(ctrl.tmode) == TM_TIMEOUT |-> dur == $past(t1) && mon_d)
    else $error("timeout fired at wrong duration");

  runt_pos_a: assert property ( // [RQ17]
    runt_st == RS_POS && !runt_above_lower && !runt_above_upper
    && ctrl.mode == VPRT_MODE_RUNT && ctrl.runt_pol != RP_NEG
    |=> trig_out && runt_st == RS_IDLE)
    else $error("positive runt missed");

  runt_abort_a: assert property ( // [RQ16]
    runt_st == RS_NEG && !runt_above_lower |=> runt_st == RS_IDLE && !trig_out)
    else $error("negative runt not cancelled by lower crossing");

  thr_keep_a: assert property ( // [RQ19]
    find_done && !find_ok && !(reg_wr && reg_addr == OFS_THR)
    |=> $stable(upper_threshold) && $stable(lower_threshold))
    else $error("failed search changed thresholds");

  runt_cov: cover property (runt_st == RS_POS ##1 trig_out);
  edge_cov: cover property (ctrl.mode == VPRT_MODE_PATTERN && pat_fire ##1 trig_out);
  line_cov: cover property (ctrl.vsel == VID_LINE_NUM && video_fire);
  band_cov: cover property (ctrl.tmode == TM_EQUAL && ctrl.duration && pat_fire);

endmodule

// file: inc/vprt_pkg.sv
// shared constants, register map and types of the trigger qualifier
package vprt_pkg;

  // ----------------------------------------------------------------
  // clock and widths
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int DUR_W         = 24;
  localparam int PAT_W         = 20;
  localparam int LINE_W        = 11;
  localparam int THR_W         = 16;
  localparam int SYNC_W        = 12;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CARE = 8'h04;
  localparam logic [7:0] OFS_VAL  = 8'h08;
  localparam logic [7:0] OFS_T1   = 8'h0C;
  localparam logic [7:0] OFS_VAR  = 8'h10;
  localparam logic [7:0] OFS_T2   = 8'h14;
  localparam logic [7:0] OFS_LINE = 8'h18;
  localparam logic [7:0] OFS_THR  = 8'h1C;
  localparam logic [7:0] OFS_STAT = 8'h20;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [DUR_W-1:0]  RST_T1    = 24'h000064;
  localparam logic [DUR_W-1:0]  RST_VAR   = 24'h00000A;
  localparam logic [DUR_W-1:0]  RST_T2    = 24'h0000C8;
  localparam logic [LINE_W-1:0] RST_LINE  = 11'h001;
  localparam logic [THR_W-1:0]  RST_UPPER = 16'hA000;
  localparam logic [THR_W-1:0]  RST_LOWER = 16'h6000;

  // ----------------------------------------------------------------
  // video timing: nominal line period per line structure
  // ----------------------------------------------------------------
  localparam int LINE_NS_625  = 64000;
  localparam int LINE_NS_525  = 63556;
  localparam int LINE_NS_750  = 22222;
  localparam int LINE_NS_1125 = 29630;
  localparam int LINE_CYC_625  = LINE_NS_625 / CLK_PERIOD_NS;
  localparam int LINE_CYC_525  = LINE_NS_525 / CLK_PERIOD_NS;
  localparam int LINE_CYC_750  = LINE_NS_750 / CLK_PERIOD_NS;
  localparam int LINE_CYC_1125 = LINE_NS_1125 / CLK_PERIOD_NS;
  localparam logic [3:0] VERT_REARM = 4'h8;

  // ----------------------------------------------------------------
  // modes and configuration
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VPRT_MODE_VIDEO, VPRT_MODE_PATTERN, VPRT_MODE_RUNT, VPRT_MODE_OFF
  } vprt_mode_e;

  typedef enum logic [2:0] {
    STD_PAL, STD_NTSC, STD_SECAM, STD_PALM,
    STD_576I, STD_720P, STD_1080P, STD_1080I
  } vprt_std_e;

  typedef enum logic [2:0] {
    VID_ALL_FRAMES, VID_ODD_FRAMES, VID_EVEN_FRAMES, VID_ALL_LINES, VID_LINE_NUM
  } vprt_vsel_e;

  typedef enum logic [2:0] {
    TM_TIMEOUT, TM_LONGER, TM_SHORTER, TM_EQUAL, TM_UNEQUAL, TM_INSIDE, TM_OUTSIDE
  } vprt_tmode_e;

  typedef enum logic [1:0] {
    RP_POS, RP_NEG, RP_BOTH
  } vprt_rpol_e;

  typedef enum logic [1:0] {
    RS_IDLE, RS_POS, RS_NEG
  } vprt_runt_e;

  typedef struct packed {
    logic        four_ch;
    logic        mso;
    vprt_rpol_e  runt_pol;
    vprt_tmode_e tmode;
    logic        cond_false;
    logic        duration;
    logic        pat_or;
    vprt_vsel_e  vsel;
    vprt_std_e   std;
    logic        sync_neg;
    vprt_mode_e  mode;
  } vprt_ctrl_s;

  localparam int CTRL_W = $bits(vprt_ctrl_s);

endpackage

// file: test/tb_top.sv
// self-checking bench for the trigger qualifier
`timescale 1ns/1ps
module tb_top
  import vprt_pkg::*;
;
  logic             clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, find_req = 0, find_pass = 0;
  logic [7:0]       reg_addr = 8'h00;
  logic [31:0]      reg_wdata = 32'h0, reg_rdata;
  logic             video_level = 1'b0;
  logic [3:0]       analog_level = 4'h0;
  logic [15:0]      logic_level = 16'h0, volt = 16'h0;
  logic [THR_W-1:0] find_upper, find_lower, upper_threshold, lower_threshold;
  logic             runt_above_upper, runt_above_lower, find_done, find_ok, trig_out;
  int               bad_count = 0, n_checks = 0, tcnt = 0;
  int               texp[7] = '{3, 3, 2, 2, 3, 4, 1};
  int               rexp[3] = '{1, 1, 2};

  vprt_trigger dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .video_level(video_level),
    .analog_level(analog_level), .logic_level(logic_level),
    .runt_above_upper(runt_above_upper), .runt_above_lower(runt_above_lower),
    .find_done(find_done), .find_ok(find_ok), .find_upper(find_upper),
    .find_lower(find_lower), .upper_threshold(upper_threshold),
    .lower_threshold(lower_threshold), .trig_out(trig_out));
  vprt_cmp_model cmp (.clk(clk), .volt(volt), .upper_threshold(upper_threshold),
    .lower_threshold(lower_threshold), .find_req(find_req), .find_pass(find_pass),
    .runt_above_upper(runt_above_upper), .runt_above_lower(runt_above_lower),
    .find_done(find_done), .find_ok(find_ok), .find_upper(find_upper),
    .find_lower(find_lower));

  // ----------------------------------------------------------------
  // clock, trigger counter, tasks
  // ----------------------------------------------------------------
  always #50 clk = ~clk;
  // counts every cycle the trigger stands, so a stretched pulse shows as extra
  always @(posedge clk) if (trig_out === 1'b1) tcnt++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tchk(input int exp);
    @(negedge clk);
    chk(tcnt, exp);
    tcnt = 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  // one match of n sampled cycles, then a quiet gap
  task automatic run(input int n);
    @(posedge clk);
    analog_level <= 4'h1;
    repeat (n) @(posedge clk);
    analog_level <= 4'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic vs(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge clk);
    volt <= a;
    repeat (3) @(posedge clk);
    volt <= b;
    repeat (3) @(posedge clk);
    volt <= c;
    repeat (4) @(posedge clk);
  endtask
  // one 720p line: a sync pulse of w cycles, level n between pulses
  task automatic vid(input int w, input logic n);
    @(posedge clk);
    video_level <= ~n;
    repeat (w) @(posedge clk);
    video_level <= n;
    repeat (LINE_CYC_750 - w) @(posedge clk);
  endtask
  task automatic fnd(input logic p, input logic [31:0] e);
    @(posedge clk);
    find_req <= 1'b1;
    find_pass <= p;
    @(posedge clk);
    find_req <= 1'b0;
    repeat (3) @(negedge clk);
    chk({upper_threshold, lower_threshold}, e);
    rd(OFS_THR, e);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(OFS_THR, 32'hA0006000);
    rd(OFS_T1, 32'h00000064);
    rd(8'h24, 32'h00000000);
    wr(OFS_CARE, 32'h00000011);
    wr(OFS_VAL, 32'h00000011);
    wr(OFS_CTRL, 32'h00060001);
    logic_level <= 16'h0001;
    @(posedge clk);
    analog_level <= 4'h1;
    @(posedge clk);
    @(negedge clk);
    chk(trig_out, 32'h1);
    @(negedge clk);
    chk(trig_out, 32'h0);
    @(posedge clk);
    analog_level <= 4'h0;
    logic_level <= 16'h0000;
    tchk(1);
    run(3);
    tchk(0);
    wr(OFS_CTRL, 32'h00060201);
    run(3);
    tchk(1);
    wr(OFS_CTRL, 32'h00060A01);
    run(3);
    // inverting the watched condition while it condition_absent_held already reads as one fall
    tchk(2);
    wr(OFS_CTRL, 32'h00000003);
    run(3);
    tchk(0);
    // width modes: runs of 4, 5, 7, 8 and 10 matching cycles against each limit
    wr(OFS_CARE, 32'h00000001);
    wr(OFS_VAR, 32'h00000001);
    wr(OFS_T2, 32'h00000009);
    for (int i = 0; i < 7; i++) begin
      wr(OFS_T1, (i >= 5) ? 32'h3 : 32'h6);
      wr(OFS_CTRL, 32'h00060401 | (i << 12));
      run(4);
      run(5);
      run(7);
      run(8);
      run(10);
      tchk(texp[i]);
    end
    // positive runt, full pulse, negative runt under each polarity choice
    for (int p = 0; p < 3; p++) begin
      wr(OFS_CTRL, 32'h00000002 | (p << 15));
      vs(16'h1000, 16'h8000, 16'h1000);
      vs(16'h1000, 16'hC000, 16'h1000);
      vs(16'hF000, 16'h8000, 16'hF000);
      tchk(rexp[p]);
    end
    // 720p: line-number trigger, then odd frames with inverted sync
    wr(OFS_LINE, 32'h00000003);
    wr(OFS_CTRL, 32'h00000128);
    vid(100, 1'b0);
    repeat (5) vid(20, 1'b0);
    tchk(1);
    wr(OFS_CTRL, 32'h0000006C);
    repeat (3) begin
      repeat (8) vid(20, 1'b1);
      vid(100, 1'b1);
    end
    tchk(1);
    fnd(1'b0, 32'hA0006000);
    fnd(1'b1, 32'hB0005000);
    rd(OFS_STAT, 32'h001C0001);
    final_report;
  end

  // watchdog well beyond the eight thousand or so cycles the scenarios need
  initial begin
    #3000000;
    bad_count++;
    final_report;
  end
endmodule

// file: test/vprt_cmp_model.sv
// comparator front end model: runt threshold pair and level search
`timescale 1ns/1ps
module vprt_cmp_model
  import vprt_pkg::*;
(
  input  wire logic             clk,
  input  wire logic [THR_W-1:0] volt,
  input  wire logic [THR_W-1:0] upper_threshold,
  input  wire logic [THR_W-1:0] lower_threshold,
  input  wire logic             find_req,
  input  wire logic             find_pass,
  output logic                  runt_above_upper,
  output logic                  runt_above_lower,
  output logic                  find_done,
  output logic                  find_ok,
  output logic      [THR_W-1:0] find_upper,
  output logic      [THR_W-1:0] find_lower
);
  logic [THR_W-1:0] cyc = 16'h0000;
  // crossings are registered so the qualifier only ever sees clean sampled levels
  always @(posedge clk) begin
    runt_above_upper <= volt > upper_threshold;
    runt_above_lower <= volt > lower_threshold;
    find_done        <= find_req;
    find_ok          <= find_req & find_pass;
    cyc              <= cyc + 16'h0001;
    // found levels are only meaningful with the done pulse; otherwise they wander
    find_upper       <= find_req ? 16'hB000 : cyc;
    find_lower       <= find_req ? 16'h5000 : ~cyc;
  end
endmodule
